//--- rtl/ees_defs.svh
`ifndef EES_DEFS_SVH
`define EES_DEFS_SVH

// register byte offsets
`define EES_REG_CTRL 8'h00
`define EES_REG_SUPPLY 8'h04
`define EES_REG_STATUS 8'h08
`define EES_REG_IRQ_STAT 8'h0c
`define EES_REG_IRQ_CLR 8'h10
`define EES_REG_IRQ_EN 8'h14
`define EES_REG_TIMER 8'h18

// field positions
`define EES_CTRL_ALARM_RST 0
`define EES_SUP_EXT_EN 6
`define EES_ST_EXT_WARN 0
`define EES_ST_CTRL_WARN 1
`define EES_ST_ALARM 2
`define EES_ST_CONTACTOR 3
`define EES_ST_READY 4
`define EES_ST_EXT_IN 5
`define EES_ST_EXT_EN 6
`define EES_ST_TRIP 7
`define EES_IRQ_EXT_WARN 0
`define EES_IRQ_ALARM 1
`define EES_IRQ_CTRL_WARN 2
`define EES_IRQ_W 3

// reset values
`define EES_SUPPLY_RST 8'h00
`define EES_IRQ_EN_RST 3'h0

// timing
`define EES_TIMEOUT_S 30
`define EES_CLK_HZ 100000000

`endif

//--- rtl/ees_pkg.sv
`include "ees_defs.svh"
`default_nettype none

package ees_pkg;

   typedef enum logic [1:0] {
      TMR_IDLE,
      TMR_RUN,
      TMR_DONE,
      TMR_TRIP
   } ees_tmr_t;

   typedef struct packed {
      logic sync1;
      logic sync2;
      ees_tmr_t tmr;
      logic [31:0] cnt;
      logic [7:0] supply;
      logic alarm;
      logic [`EES_IRQ_W-1:0] irq_stat;
      logic [`EES_IRQ_W-1:0] irq_en;
      logic ack;
      logic [31:0] dat;
      logic contactor;
      logic ext_warn;
      logic ctrl_warn;
      logic decel;
      logic brake;
      logic coast;
      logic ready;
      logic irq;
   } ees_state_t;

endpackage

`default_nettype wire

//--- rtl/ees_sequencer.sv
// Functional notes
// RULE1: external stop input counts only when supply type has 0x40 added.
// RULE2: enabled, asserted external input without controller stop raises external warning.
// RULE3: external warning alone causes no deceleration stop and no dynamic brake.
// RULE4: no contactor shutoff within 30 s forces contactor off and raises alarm 55.
// RULE5: controller stop within 30 s replaces external warning by controller warning.
// RULE6: controller stop then contactor shutoff settles into normal stop state.
// RULE7: ready on allowed with external input asserted; alarm 55 after 30 s.
// RULE8: delay from external input to forced shutoff is fixed at 30 s.
// RULE9: forced shutoff lets spindle coast and servos stop on dynamic brakes.
// RULE10: controller stop never starts the external stop function.
// RULE11: external input released before timeout clears warning, stops timer, no shutoff.
`include "ees_defs.svh"
`default_nettype none

module ees_sequencer #(
   parameter longint unsigned TIMEOUT_CYC = 64'(`EES_TIMEOUT_S) * 64'(`EES_CLK_HZ)
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ext_estop_n_i,
   input wire logic nc_estop_i,
   input wire logic nc_mc_off_i,
   input wire logic ready_on_req_i,
   output logic contactor_drive_o,
   output logic ext_estop_warning_o,
   output logic controller_estop_warning_o,
   output logic alarm55_o,
   output logic decel_stop_o,
   output logic servo_dyn_brake_o,
   output logic spindle_coast_o,
   output logic ready_on_ok_o,
   output logic irq_o
);

   // forced-shutoff delay is a build-time constant only, never a register
   localparam logic [31:0] TMO_LAST = 32'(TIMEOUT_CYC - 64'h1);

   // the counter is 32 bits wide: a longer delay needs a wider counter, not a bigger value
   if (TIMEOUT_CYC < 64'h1 || TIMEOUT_CYC > 64'h0000_0000_ffff_ffff) begin
      $error("TIMEOUT_CYC out of range");
   end

   ees_pkg::ees_state_t s_reg;
   ees_pkg::ees_state_t s_next;

   logic ext_act;
   logic wr;
   logic rd;
   logic alarm_rst;
   logic [`EES_IRQ_W-1:0] irq_ev;
   logic [`EES_IRQ_W-1:0] irq_clr;

   always_comb begin
      s_next = s_reg;
      // second stage only feeds logic; first stage is read by nothing else
      s_next.sync1 = ext_estop_n_i;
      s_next.sync2 = s_reg.sync1;
      ext_act = ~s_reg.sync2 & s_reg.supply[`EES_SUP_EXT_EN]; // RULE1
      wr = wb_cyc_i & wb_stb_i & wb_we_i & ~s_reg.ack;
      rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~s_reg.ack;
      alarm_rst = wr && wb_adr_i == `EES_REG_CTRL && wb_sel_i[0] &&
         wb_dat_i[`EES_CTRL_ALARM_RST];
      irq_clr = '0;

      // register writes
      if (wr && wb_adr_i == `EES_REG_SUPPLY && wb_sel_i[0]) begin
         s_next.supply = wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == `EES_REG_IRQ_EN && wb_sel_i[0]) begin
         s_next.irq_en = wb_dat_i[`EES_IRQ_W-1:0];
      end
      if (wr && wb_adr_i == `EES_REG_IRQ_CLR && wb_sel_i[0]) begin
         irq_clr = wb_dat_i[`EES_IRQ_W-1:0];
      end

      // only the dedicated input starts the timer, never a controller stop
      case (s_reg.tmr)
         ees_pkg::TMR_IDLE: begin
            s_next.cnt = '0;
            if (ext_act) begin // RULE10
               s_next.tmr = ees_pkg::TMR_RUN;
            end
         end
         ees_pkg::TMR_RUN: begin
            s_next.cnt = s_reg.cnt + 32'h1;
            if (nc_mc_off_i) begin
               s_next.tmr = ees_pkg::TMR_DONE; // RULE6
            end else if (!ext_act) begin
               s_next.tmr = ees_pkg::TMR_IDLE; // RULE11
            end else if (s_reg.cnt == TMO_LAST) begin
               s_next.tmr = ees_pkg::TMR_TRIP; // RULE4 RULE8
               s_next.alarm = 1'b1; // RULE7
            end
         end
         ees_pkg::TMR_DONE: begin
            if (!ext_act) begin
               s_next.tmr = ees_pkg::TMR_IDLE;
            end
         end
         ees_pkg::TMR_TRIP: begin
            // a forced shutoff holds until released and reset by software
            if (alarm_rst && !ext_act) begin
               s_next.tmr = ees_pkg::TMR_IDLE;
            end
         end
         default: begin
            s_next.tmr = ees_pkg::TMR_IDLE;
         end
      endcase
      if (alarm_rst && s_next.tmr != ees_pkg::TMR_TRIP) begin
         s_next.alarm = 1'b0;
      end

      // outputs, registered once
      s_next.ext_warn = (s_next.tmr == ees_pkg::TMR_RUN) & ~nc_estop_i; // RULE2 RULE5
      s_next.ctrl_warn = nc_estop_i; // RULE5 RULE6
      s_next.decel = nc_estop_i & (s_next.tmr != ees_pkg::TMR_TRIP); // RULE3
      s_next.brake = s_next.tmr == ees_pkg::TMR_TRIP; // RULE9
      s_next.coast = s_next.tmr == ees_pkg::TMR_TRIP; // RULE9
      // the external input alone keeps ready open; only a trip or the controller closes it
      s_next.ready = ~nc_estop_i & ~nc_mc_off_i & (s_next.tmr != ees_pkg::TMR_TRIP); // RULE7
      s_next.contactor = ready_on_req_i & s_next.ready; // RULE4

      // sticky events: a new event wins over a clear in the same cycle
      irq_ev = '0;
      irq_ev[`EES_IRQ_EXT_WARN] = s_next.ext_warn & ~s_reg.ext_warn;
      irq_ev[`EES_IRQ_ALARM] = s_next.alarm & ~s_reg.alarm;
      irq_ev[`EES_IRQ_CTRL_WARN] = s_next.ctrl_warn & ~s_reg.ctrl_warn;
      s_next.irq_stat = (s_reg.irq_stat & ~irq_clr) | irq_ev;
      s_next.irq = |(s_next.irq_stat & s_next.irq_en);

      // bus answer: one-cycle ack, unmapped reads return zero
      s_next.ack = wb_cyc_i & wb_stb_i & ~s_reg.ack;
      s_next.dat = '0;
      if (rd) begin
         case (wb_adr_i)
            `EES_REG_SUPPLY: s_next.dat = {24'h0, s_reg.supply};
            `EES_REG_STATUS: begin
               s_next.dat[`EES_ST_EXT_WARN] = s_reg.ext_warn;
               s_next.dat[`EES_ST_CTRL_WARN] = s_reg.ctrl_warn;
               s_next.dat[`EES_ST_ALARM] = s_reg.alarm;
               s_next.dat[`EES_ST_CONTACTOR] = s_reg.contactor;
               s_next.dat[`EES_ST_READY] = s_reg.ready;
               s_next.dat[`EES_ST_EXT_IN] = ~s_reg.sync2;
               s_next.dat[`EES_ST_EXT_EN] = s_reg.supply[`EES_SUP_EXT_EN];
               s_next.dat[`EES_ST_TRIP] = s_reg.tmr == ees_pkg::TMR_TRIP;
            end
            `EES_REG_IRQ_STAT: s_next.dat[`EES_IRQ_W-1:0] = s_reg.irq_stat;
            `EES_REG_IRQ_EN: s_next.dat[`EES_IRQ_W-1:0] = s_reg.irq_en;
            `EES_REG_TIMER: s_next.dat = s_reg.cnt;
            default: s_next.dat = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.sync1 <= 1'b1;
         s_reg.sync2 <= 1'b1;
         s_reg.tmr <= ees_pkg::TMR_IDLE;
         s_reg.supply <= `EES_SUPPLY_RST;
         s_reg.irq_en <= `EES_IRQ_EN_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wb_dat_o = s_reg.dat;
   assign wb_ack_o = s_reg.ack;
   assign contactor_drive_o = s_reg.contactor;
   assign ext_estop_warning_o = s_reg.ext_warn;
   assign controller_estop_warning_o = s_reg.ctrl_warn;
   assign alarm55_o = s_reg.alarm;
   assign decel_stop_o = s_reg.decel;
   assign servo_dyn_brake_o = s_reg.brake;
   assign spindle_coast_o = s_reg.coast;
   assign ready_on_ok_o = s_reg.ready;
   assign irq_o = s_reg.irq;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_ignore_disabled: // RULE1
   assert property ((s_reg.tmr == ees_pkg::TMR_IDLE && !s_reg.supply[`EES_SUP_EXT_EN])
      |=> s_reg.tmr == ees_pkg::TMR_IDLE)
      else $error("timer started while external input disabled");

   a_ext_warn_raise: // RULE2
   assert property ((s_reg.tmr == ees_pkg::TMR_RUN && ext_act && !nc_estop_i
      && !nc_mc_off_i && s_reg.cnt != TMO_LAST) |=> ext_estop_warning_o)
      else $error("external warning not raised");

   a_warn_no_stop: // RULE3
   assert property ((ext_estop_warning_o && !controller_estop_warning_o)
      |-> (!decel_stop_o && !servo_dyn_brake_o))
      else $error("external warning alone caused a stop");

   a_trip_timeout: // RULE4
   assert property ((s_reg.tmr == ees_pkg::TMR_RUN && s_reg.cnt == TMO_LAST
      && ext_act && !nc_mc_off_i) |=> (alarm55_o && !contactor_drive_o)
      ##1 (alarm55_o && !contactor_drive_o))
      else $error("timeout did not force shutoff");

   a_fixed_delay: // RULE8
   assert property ($rose(s_reg.tmr == ees_pkg::TMR_TRIP)
      |-> $past(s_reg.cnt) == TMO_LAST)
      else $error("forced shutoff at wrong count");

   a_ctrl_replaces: // RULE5
   assert property ((nc_estop_i && s_reg.tmr == ees_pkg::TMR_RUN)
      |=> (!ext_estop_warning_o && controller_estop_warning_o))
      else $error("controller warning did not replace external warning");

   a_mc_off_settle: // RULE6
   assert property ((s_reg.tmr == ees_pkg::TMR_RUN && nc_mc_off_i && nc_estop_i)
      |=> (s_reg.tmr == ees_pkg::TMR_DONE && controller_estop_warning_o
      && !alarm55_o ##1 !alarm55_o))
      else $error("normal stop state not reached");

   a_ready_with_ext: // RULE7
   assert property ((ext_act && ready_on_req_i && !nc_estop_i && !nc_mc_off_i
      && s_reg.tmr == ees_pkg::TMR_RUN && s_reg.cnt != TMO_LAST)
      |=> (ready_on_ok_o && contactor_drive_o))
      else $error("ready on refused with external input");

   a_trip_coast: // RULE9
   assert property ((s_reg.tmr == ees_pkg::TMR_TRIP)
      |-> (spindle_coast_o && servo_dyn_brake_o && !contactor_drive_o))
      else $error("forced shutoff without coast and brake");

   a_nc_no_start: // RULE10
   assert property ((s_reg.tmr == ees_pkg::TMR_IDLE && !ext_act && nc_estop_i)
      |=> (s_reg.tmr == ees_pkg::TMR_IDLE ##1 !ext_estop_warning_o))
      else $error("controller stop started the external function");

   a_release_clear: // RULE11
   assert property ((s_reg.tmr == ees_pkg::TMR_RUN && !ext_act && !nc_mc_off_i)
      |=> (s_reg.tmr == ees_pkg::TMR_IDLE && !alarm55_o
      ##1 (!ext_estop_warning_o && s_reg.cnt == 32'h0)))
      else $error("release did not clear the timer");

   a_irq_level:
   assert property (irq_o == |(s_reg.irq_stat & s_reg.irq_en))
      else $error("interrupt level mismatch");

   a_irq_stat_sticky:
   assert property ((s_reg.irq_stat[`EES_IRQ_ALARM] && !irq_clr[`EES_IRQ_ALARM])
      |=> s_reg.irq_stat[`EES_IRQ_ALARM])
      else $error("interrupt status lost without clear");

   // bus side: a registered answer, so ack never stands for two cycles in a row
   a_ack_one_cycle:
   assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack stood for more than one cycle");

   a_ack_follows_req:
   assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered in one cycle");

   a_dat_idle_zero:
   assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");

   a_supply_write: // RULE1
   assert property ((wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
      && wb_adr_i == `EES_REG_SUPPLY) |=> s_reg.supply[`EES_SUP_EXT_EN]
      == $past(wb_dat_i[`EES_SUP_EXT_EN]))
      else $error("enable bit not written");

   // timer side: the count starts from zero and only moves forward while running
   a_idle_cnt_zero: // RULE8
   assert property (s_reg.tmr == ees_pkg::TMR_IDLE |=> s_reg.cnt == 32'h0)
      else $error("timer not cleared while idle");

   a_timer_counts: // RULE8
   assert property ((s_reg.tmr == ees_pkg::TMR_RUN && ext_act && !nc_mc_off_i
      && s_reg.cnt != TMO_LAST) |=> s_reg.cnt == $past(s_reg.cnt) + 32'h1)
      else $error("timer skipped or stalled");

   a_ext_warn_run: // RULE2
   assert property (ext_estop_warning_o |-> (s_reg.tmr == ees_pkg::TMR_RUN
      && !controller_estop_warning_o))
      else $error("external warning outside a running timer");

   a_ctrl_warn_follows: // RULE5
   assert property (nc_estop_i |=> controller_estop_warning_o)
      else $error("controller warning missing");

   a_done_holds: // RULE6
   assert property ((s_reg.tmr == ees_pkg::TMR_DONE && ext_act)
      |=> (s_reg.tmr == ees_pkg::TMR_DONE && !alarm55_o))
      else $error("normal stop state left while input held");

   // trip side: the shutoff is latched so a bouncing input cannot close the contactor again
   a_trip_holds: // RULE4
   assert property ((s_reg.tmr == ees_pkg::TMR_TRIP && !alarm_rst)
      |=> s_reg.tmr == ees_pkg::TMR_TRIP)
      else $error("forced shutoff left without alarm reset");

   a_alarm_only_trip: // RULE4
   assert property ($rose(alarm55_o) |-> s_reg.tmr == ees_pkg::TMR_TRIP)
      else $error("alarm raised without forced shutoff");

   a_alarm_sticky: // RULE4
   assert property ((alarm55_o && !alarm_rst) |=> alarm55_o)
      else $error("alarm cleared without reset");

   a_trip_not_ready: // RULE4
   assert property (s_reg.tmr == ees_pkg::TMR_TRIP |-> !ready_on_ok_o)
      else $error("ready on allowed during forced shutoff");

   a_trip_no_warn: // RULE4
   assert property (s_reg.tmr == ees_pkg::TMR_TRIP |-> !ext_estop_warning_o)
      else $error("external warning during forced shutoff");

   a_contactor_gate: // RULE4
   assert property (contactor_drive_o |-> ready_on_ok_o)
      else $error("contactor closed without ready on");

   a_decel_no_coast: // RULE9
   assert property (decel_stop_o |-> !spindle_coast_o)
      else $error("deceleration and coast together");

   a_coast_brake_pair: // RULE9
   assert property (spindle_coast_o == servo_dyn_brake_o)
      else $error("coast and dynamic brake apart");

   c_ext_warn: cover property ($rose(ext_estop_warning_o));
   c_trip: cover property ($rose(s_reg.tmr == ees_pkg::TMR_TRIP));
   c_replace: cover property (ext_estop_warning_o ##1 controller_estop_warning_o);
   c_release: cover property (s_reg.tmr == ees_pkg::TMR_RUN ##1
      s_reg.tmr == ees_pkg::TMR_IDLE);
   c_settle: cover property (s_reg.tmr == ees_pkg::TMR_RUN ##1
      s_reg.tmr == ees_pkg::TMR_DONE);

endmodule

`default_nettype wire

//--- tb/ees_nc_model.sv
`default_nettype none
module ees_nc_model #(
   parameter int MC_DLY = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic estop_cmd_i,
   input wire logic mc_hold_i,
   input wire logic ready_cmd_i,
   output logic nc_estop_o,
   output logic nc_mc_off_o,
   output logic ready_on_req_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // shutoff waits for zero speed; mc_hold stands for a controller that never gets there
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 0;
         nc_estop_o <= 1'b0;
         nc_mc_off_o <= 1'b0;
         ready_on_req_o <= 1'b0;
      end else begin
         cnt <= estop_cmd_i ? cnt + 1 : 0;
         nc_estop_o <= estop_cmd_i;
         nc_mc_off_o <= estop_cmd_i && !mc_hold_i && cnt >= MC_DLY;
         ready_on_req_o <= ready_cmd_i && !estop_cmd_i;
      end
   end
endmodule
`default_nettype wire

//--- tb/external_estop_contactor_sequencer_tb.sv
`include "ees_defs.svh"
`default_nettype none
module external_estop_contactor_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam longint unsigned TO = 50;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pin_n = 1'b1, est = 1'b0, rdy = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
   logic wb_ack_o, nc_e, nc_mc, nc_rdy, cont, ewarn, cwarn, alarm, decel, brake, coast, rok, irq;
   int n_errors = 0;
   int n_checks = 0;
   always #5 clk_i = ~clk_i;
   ees_sequencer #(.TIMEOUT_CYC(TO)) ees_sequencer_i (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_estop_n_i(pin_n),
      .nc_estop_i(nc_e), .nc_mc_off_i(nc_mc), .ready_on_req_i(nc_rdy),
      .contactor_drive_o(cont), .ext_estop_warning_o(ewarn),
      .controller_estop_warning_o(cwarn), .alarm55_o(alarm), .decel_stop_o(decel),
      .servo_dyn_brake_o(brake), .spindle_coast_o(coast), .ready_on_ok_o(rok), .irq_o(irq));
   ees_nc_model ees_nc_model_i (.clk_i(clk_i), .rst_i(rst_i), .estop_cmd_i(est),
      .mc_hold_i(1'b0), .ready_cmd_i(rdy), .nc_estop_o(nc_e), .nc_mc_off_o(nc_mc),
      .ready_on_req_o(nc_rdy));
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one classic cycle; read data is taken at the ack edge, before anything is released
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      // no wait-state count is assumed; only the watchdog ends a hang
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      wb(1'b0, a, 32'h0);
      chk(name, rdat, exp);
   endtask
   task automatic cyc_wait(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      cyc_wait(3000);
      n_errors++;
      complete_run();
   end
   initial begin
      cyc_wait(16);
      rst_i <= 1'b0;
      rd(`EES_REG_SUPPLY, 32'h0, "supply");
      rd(`EES_REG_IRQ_EN, 32'h0, "irq_en");
      // ready is open as soon as reset ends: no controller stop is pending
      rd(`EES_REG_STATUS, 32'h10, "status");
      rd(8'h40, 32'h0, "unmapped");
      $display("test reset done");
      pin_n <= 1'b0;
      cyc_wait(60);
      chk("ext_warn", ewarn, 1'b0);
      chk("alarm", alarm, 1'b0);
      pin_n <= 1'b1;
      $display("test disabled done");
      wb(1'b1, `EES_REG_SUPPLY, 32'h40);
      wb(1'b1, `EES_REG_IRQ_EN, 32'h7);
      rdy <= 1'b1;
      cyc_wait(4);
      chk("contactor", cont, 1'b1);
      pin_n <= 1'b0;
      cyc_wait(10);
      chk("ext_warn", ewarn, 1'b1);
      chk("decel", decel, 1'b0);
      chk("brake", brake, 1'b0);
      chk("ready_ok", rok, 1'b1);
      chk("irq", irq, 1'b1);
      // trip lands TO cycles after the timer starts, which is three edges after the pin falls
      cyc_wait(int'(TO) - 7);
      chk("alarm early", alarm, 1'b0);
      chk("ready_ok late", rok, 1'b1);
      cyc_wait(1);
      chk("alarm", alarm, 1'b1);
      chk("contactor", cont, 1'b0);
      chk("coast", coast, 1'b1);
      chk("brake", brake, 1'b1);
      rd(`EES_REG_IRQ_STAT, 32'h3, "irq_stat");
      wb(1'b1, `EES_REG_IRQ_CLR, 32'h7);
      wb(1'b1, `EES_REG_IRQ_EN, 32'h0);
      rd(`EES_REG_IRQ_STAT, 32'h0, "irq_stat clr");
      pin_n <= 1'b1;
      cyc_wait(4);
      wb(1'b1, `EES_REG_CTRL, 32'h1);
      cyc_wait(3);
      chk("alarm rst", alarm, 1'b0);
      chk("contactor", cont, 1'b1);
      $display("test timeout done");
      pin_n <= 1'b0;
      cyc_wait(10);
      est <= 1'b1;
      cyc_wait(4);
      chk("ext_warn", ewarn, 1'b0);
      chk("ctrl_warn", cwarn, 1'b1);
      chk("decel", decel, 1'b1);
      cyc_wait(60);
      chk("alarm", alarm, 1'b0);
      chk("ctrl_warn", cwarn, 1'b1);
      chk("contactor", cont, 1'b0);
      chk("irq masked", irq, 1'b0);
      rd(`EES_REG_IRQ_STAT, 32'h5, "irq_stat");
      pin_n <= 1'b1;
      $display("test controller stop done");
      cyc_wait(60);
      chk("ext_warn", ewarn, 1'b0);
      chk("alarm", alarm, 1'b0);
      rd(`EES_REG_TIMER, 32'h0, "timer");
      est <= 1'b0;
      cyc_wait(5);
      pin_n <= 1'b0;
      cyc_wait(20);
      pin_n <= 1'b1;
      cyc_wait(60);
      chk("ext_warn", ewarn, 1'b0);
      chk("alarm", alarm, 1'b0);
      chk("contactor", cont, 1'b1);
      $display("test release done");
      complete_run();
   end
endmodule
`default_nettype wire
